// File: core/sci_irq_top.sv
// What this block does
// - match-one flag sets on match, read clears
// - transmit-sync flag sets on event, read clears
// - receive-sync flag sets on event, read clears
// - transmit-enabled bit mirrors transmitter enable
// - receive-enabled bit mirrors receiver enable
// - status, set, clear, mask share layout
// - set register ones enable sources
// - clear register ones disable sources
// - mask register shows enabled sources
// - receive ready tracks holding register occupancy
// - overrun on load while full, read clears
// - match-zero flag sets on match, read clears
`timescale 1ns/10ps
`include "sci_map.svh"

module sci_irq_top
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_tx_ready,
	input  wire logic        i_tx_drained,
	input  wire logic        i_tx_count_done,
	input  wire logic        i_tx_buffers_empty,
	input  wire logic        i_rx_count_done,
	input  wire logic        i_rx_buffers_full,
	input  wire logic        i_rx_load,
	input  wire logic        i_rx_take,
	input  wire logic        i_match_zero,
	input  wire logic        i_match_one,
	input  wire logic        i_transmit_sync,
	input  wire logic        i_receive_sync,
	input  wire logic        i_tx_enabled,
	input  wire logic        i_rx_enabled,
	output logic             o_irq
);
	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = hit(addr, `SCI_OFS_STATUS) | hit(addr, `SCI_OFS_EN_SET)
			| hit(addr, `SCI_OFS_EN_CLEAR) | hit(addr, `SCI_OFS_MASK_STATE)
			| hit(addr, `SCI_OFS_FLAG_CLEAR);
	endfunction

	sci_pkg::sci_top_s q;
	sci_pkg::sci_top_s d;

	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic [31:0] rdata;
	logic [31:0] status_word;
	logic [11:0] sticky;
	logic [11:0] flags_all;
	logic [11:0] sticky_set;
	logic [11:0] sticky_clr;
	logic [11:0] en_set;
	logic [11:0] en_clr;
	logic        status_read;
	logic        overrun_event;

	assign addr_ok = mapped(i_paddr);

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	sci_apb_slave u_apb
	(
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_psel    (i_psel),
		.i_penable (i_penable),
		.i_pwrite  (i_pwrite),
		.i_rdata   (rdata),
		.i_addr_ok (addr_ok),
		.o_wr_en   (wr_en),
		.o_rd_en   (rd_en),
		.o_pready  (o_pready),
		.o_pslverr (o_pslverr),
		.o_prdata  (o_prdata)
	);

	// ---------------------------------------------------------------
	// status word
	// ---------------------------------------------------------------
	// one layout for every register, so a source's bit index is the same everywhere
	always_comb
	begin
		flags_all = q.level | sticky;
		flags_all[`SCI_BIT_RX_READY] = q.rx_full;
		status_word = `SCI_ZERO_WORD;
		status_word[11:0] = flags_all;
		status_word[`SCI_BIT_TX_ENABLED] = q.tx_en;
		status_word[`SCI_BIT_RX_ENABLED] = q.rx_en;
	end

	always_comb
	begin
		rdata = `SCI_ZERO_WORD;
		if (hit(i_paddr, `SCI_OFS_STATUS))
			rdata = status_word;
		else if (hit(i_paddr, `SCI_OFS_MASK_STATE))
			rdata[11:0] = q.mask;
	end

	// ---------------------------------------------------------------
	// sticky event flags
	// ---------------------------------------------------------------
	// a word read out in the same cycle as the next load is no overrun
	assign overrun_event = i_rx_load & q.rx_full & ~i_rx_take;
	assign status_read = rd_en & hit(i_paddr, `SCI_OFS_STATUS);

	always_comb
	begin
		sticky_set = '0;
		sticky_set[`SCI_BIT_RX_OVERRUN] = overrun_event;
		sticky_set[`SCI_BIT_MATCH_ZERO] = i_match_zero;
		sticky_set[`SCI_BIT_MATCH_ONE] = i_match_one;
		sticky_set[`SCI_BIT_TX_SYNC] = i_transmit_sync;
		sticky_set[`SCI_BIT_RX_SYNC] = i_receive_sync;
		// only bits that the reader actually saw are cleared, so an event
		// landing between the data sample and the ack edge is kept
		sticky_clr = '0;
		if (status_read)
			sticky_clr = o_prdata[11:0] & `SCI_STICKY_BITS;
		if (wr_en & hit(i_paddr, `SCI_OFS_FLAG_CLEAR))
			sticky_clr = sticky_clr | (i_pwdata[11:0] & `SCI_STICKY_BITS);
	end

	sci_flags u_flags
	(
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_set   (sticky_set),
		.i_clr   (sticky_clr),
		.o_flags (sticky)
	);

	// ---------------------------------------------------------------
	// mask, levels and interrupt
	// ---------------------------------------------------------------
	always_comb
	begin
		en_set = '0;
		en_clr = '0;
		if (wr_en & hit(i_paddr, `SCI_OFS_EN_SET))
			en_set = i_pwdata[11:0];
		if (wr_en & hit(i_paddr, `SCI_OFS_EN_CLEAR))
			en_clr = i_pwdata[11:0];
	end

	always_comb
	begin
		d = q;
		d.mask = (q.mask | en_set) & ~en_clr;
		d.level = '0;
		d.level[`SCI_BIT_TX_READY] = i_tx_ready;
		d.level[`SCI_BIT_TX_DRAINED] = i_tx_drained;
		d.level[`SCI_BIT_TX_DONE] = i_tx_count_done;
		d.level[`SCI_BIT_TX_BUFE] = i_tx_buffers_empty;
		d.level[`SCI_BIT_RX_DONE] = i_rx_count_done;
		d.level[`SCI_BIT_RX_BUFF] = i_rx_buffers_full;
		if (i_rx_load)
			d.rx_full = 1'b1;
		else if (i_rx_take)
			d.rx_full = 1'b0;
		d.tx_en = i_tx_enabled;
		d.rx_en = i_rx_enabled;
		// registered so the pin never glitches; one cycle behind the flags
		d.irq = |(flags_all & q.mask);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			q <= '0;
			q.mask <= `SCI_MASK_RESET;
		end
		else
			q <= d;
	end

	assign o_irq = q.irq;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_status_done;
		rd_en && hit(i_paddr, `SCI_OFS_STATUS);
	endsequence

	sequence s_write(logic [7:0] ofs);
		wr_en && hit(i_paddr, ofs);
	endsequence

	a_match_one_set: assert property (i_match_one |=> sticky[`SCI_BIT_MATCH_ONE])
		else $error("match-one event did not set its flag");

	a_match_one_clr: assert property (s_status_done ##0 (o_prdata[`SCI_BIT_MATCH_ONE] && !i_match_one)
		|=> !sticky[`SCI_BIT_MATCH_ONE])
		else $error("match-one flag survived a status read");

	a_tx_sync_flag: assert property (s_status_done ##0 (o_prdata[`SCI_BIT_TX_SYNC] && !i_transmit_sync)
		|=> !sticky[`SCI_BIT_TX_SYNC] ##0 $past(i_transmit_sync) == 1'b0)
		else $error("transmit-sync flag not cleared by read");

	a_rx_sync_keep: assert property (i_receive_sync |=> sticky[`SCI_BIT_RX_SYNC])
		else $error("receive-sync event lost");

	a_tx_en_view: assert property (##1 status_word[`SCI_BIT_TX_ENABLED] == $past(i_tx_enabled))
		else $error("transmit-enabled bit does not follow enable");

	a_rx_en_view: assert property (##1 status_word[`SCI_BIT_RX_ENABLED] == $past(i_rx_enabled))
		else $error("receive-enabled bit does not follow enable");

	a_layout_upper: assert property (status_word[15:12] == 4'h0 && status_word[31:18] == 14'h0)
		else $error("unused status bits not zero");

	a_mask_set: assert property (s_write(`SCI_OFS_EN_SET)
		|=> ((q.mask & $past(i_pwdata[11:0])) == $past(i_pwdata[11:0])))
		else $error("enable-set write did not enable sources");

	a_mask_clr: assert property (s_write(`SCI_OFS_EN_CLEAR)
		|=> ((q.mask & $past(i_pwdata[11:0])) == 12'h000)
		&& ((q.mask | $past(i_pwdata[11:0])) == ($past(q.mask) | $past(i_pwdata[11:0]))))
		else $error("enable-clear write wrong");

	a_mask_read: assert property (rd_en && hit(i_paddr, `SCI_OFS_MASK_STATE)
		|-> o_prdata == {20'h00000, $past(q.mask)})
		else $error("mask read does not show enabled sources");

	a_rx_ready_flow: assert property (i_rx_load ##1 !i_rx_take[*2]
		|-> flags_all[`SCI_BIT_RX_READY])
		else $error("receive ready dropped without a take");

	a_overrun_set: assert property (i_rx_load && q.rx_full && !i_rx_take
		|=> sticky[`SCI_BIT_RX_OVERRUN])
		else $error("overrun not flagged");

	a_match_zero_set: assert property (i_match_zero |=> sticky[`SCI_BIT_MATCH_ZERO])
		else $error("match-zero event did not set its flag");

	a_irq_level: assert property (##1 o_irq == $past(|(flags_all & q.mask)))
		else $error("interrupt output disagrees with flags and mask");

	a_mask_reset: assert property (@(posedge i_clk) disable iff (1'b0)
		$fell(i_rst) |-> (q.mask == 12'h000 && !o_irq))
		else $error("mask not zero after reset");

	a_clear_wins: assert property (en_set[0] && en_clr[0] |=> !q.mask[0])
		else $error("clear lost to set");

	a_pready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready held longer than one cycle");

	a_slverr_unmapped: assert property (i_psel && i_penable && !o_pready && !addr_ok
		|=> o_pready && o_pslverr)
		else $error("unmapped access not answered with error");
endmodule

// File: core/sci_map.svh
`ifndef SCI_MAP_SVH
`define SCI_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SCI_OFS_STATUS      8'h00
`define SCI_OFS_EN_SET      8'h04
`define SCI_OFS_EN_CLEAR    8'h08
`define SCI_OFS_MASK_STATE  8'h0C
`define SCI_OFS_FLAG_CLEAR  8'h10

// ---------------------------------------------------------------
// shared bit layout of status, set, clear and mask
// ---------------------------------------------------------------
`define SCI_NSRC            12
`define SCI_BIT_TX_READY    0
`define SCI_BIT_TX_DRAINED  1
`define SCI_BIT_TX_DONE     2
`define SCI_BIT_TX_BUFE     3
`define SCI_BIT_RX_READY    4
`define SCI_BIT_RX_OVERRUN  5
`define SCI_BIT_RX_DONE     6
`define SCI_BIT_RX_BUFF     7
`define SCI_BIT_MATCH_ZERO  8
`define SCI_BIT_MATCH_ONE   9
`define SCI_BIT_TX_SYNC     10
`define SCI_BIT_RX_SYNC     11
`define SCI_BIT_TX_ENABLED  16
`define SCI_BIT_RX_ENABLED  17

// ---------------------------------------------------------------
// reset values and masks
// ---------------------------------------------------------------
`define SCI_MASK_RESET      12'h000
`define SCI_FLAGS_RESET     12'h000
`define SCI_STICKY_BITS     12'hF20
`define SCI_ZERO_WORD       32'h0000_0000

`endif

// File: core/sci_pkg.sv
package sci_pkg;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} sci_apb_s;

	typedef struct packed {
		logic [11:0] flags;
	} sci_flags_s;

	typedef struct packed {
		logic [11:0] mask;
		logic [11:0] level;
		logic        rx_full;
		logic        tx_en;
		logic        rx_en;
		logic        irq;
	} sci_top_s;

endpackage

// File: core/sci_apb_slave.sv
`timescale 1ns/10ps
`include "sci_map.svh"

// ---------------------------------------------------------------
// apb slave: one wait state, read data sampled before the ack
// ---------------------------------------------------------------
module sci_apb_slave
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_rdata,
	input  wire logic        i_addr_ok,
	output logic             o_wr_en,
	output logic             o_rd_en,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic [31:0]      o_prdata
);
	sci_pkg::sci_apb_s q;
	sci_pkg::sci_apb_s d;
	logic              done;

	assign done = i_psel & i_penable & q.pready;
	assign o_wr_en = done & i_pwrite & i_addr_ok;
	assign o_rd_en = done & ~i_pwrite & i_addr_ok;
	assign o_pready = q.pready;
	assign o_pslverr = q.pslverr;
	assign o_prdata = q.prdata;

	always_comb
	begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		if (i_psel & i_penable & ~q.pready)
		begin
			d.pready = 1'b1;
			d.pslverr = ~i_addr_ok;
			d.prdata = (i_pwrite | ~i_addr_ok) ? `SCI_ZERO_WORD : i_rdata;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			q <= '0;
		else
			q <= d;
	end
endmodule

// File: core/sci_flags.sv
`timescale 1ns/10ps
`include "sci_map.svh"

// ---------------------------------------------------------------
// sticky flags: a set in the clearing cycle survives
// ---------------------------------------------------------------
module sci_flags
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [11:0] i_set,
	input  wire logic [11:0] i_clr,
	output logic [11:0]      o_flags
);
	sci_pkg::sci_flags_s q;
	sci_pkg::sci_flags_s d;

	assign o_flags = q.flags;

	always_comb
	begin
		d = q;
		d.flags = (q.flags & ~i_clr) | i_set;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			q.flags <= `SCI_FLAGS_RESET;
		else
			q <= d;
	end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/10ps
`include "sci_map.svh"

module tb_top;

	logic        i_clk;
	logic        i_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  lv;
	logic [1:0]  en;
	logic [3:0]  evt;
	logic        rx_load;
	logic        rx_take;
	logic        irq;
	int          errors;
	int          checks_done;
	int          mask_m;
	int          stk_m;
	int          receive_ready_flag_m;
	int          ovr_m;
	int          seed;
	logic [31:0] rd;
	logic        er;
	logic [31:0] sv;

	sci_irq_top i_sci_irq_top (
		.i_clk              (i_clk),
		.i_rst              (i_rst),
		.i_psel             (psel),
		.i_penable          (penable),
		.i_pwrite           (pwrite),
		.i_paddr            (paddr),
		.i_pwdata           (pwdata),
		.o_prdata           (prdata),
		.o_pready           (pready),
		.o_pslverr          (pslverr),
		.i_tx_ready         (lv[0]),
		.i_tx_drained       (lv[1]),
		.i_tx_count_done    (lv[2]),
		.i_tx_buffers_empty (lv[3]),
		.i_rx_count_done    (lv[4]),
		.i_rx_buffers_full  (lv[5]),
		.i_rx_load          (rx_load),
		.i_rx_take          (rx_take),
		.i_match_zero       (evt[0]),
		.i_match_one        (evt[1]),
		.i_transmit_sync    (evt[2]),
		.i_receive_sync     (evt[3]),
		.i_tx_enabled       (en[0]),
		.i_rx_enabled       (en[1]),
		.o_irq              (irq)
	);

	always #4 i_clk = ~i_clk;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task summarize;
		if (errors == 0 && checks_done > 0)
		begin
			$display("TEST PASSED");
		end
		else
		begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			errors++;
		end
	endtask

	// request held until pready is seen high at a rising edge; pready is looked at
	// mid-cycle, where it already holds the value that the next rising edge samples,
	// so the bench never races the register that launches it
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		@(negedge i_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(negedge i_clk);
		end
		if (n == 20)
		begin
			errors++;
		end
		rd = prdata;
		er = pslverr;
		@(posedge i_clk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task pulse_ev(input logic [3:0] e);
		@(posedge i_clk);
		evt <= e;
		@(posedge i_clk);
		evt <= 4'h0;
	endtask

	function logic [31:0] exp_status();
		logic [31:0] e;
		e = 32'h0000_0000;
		e[3:0]  = lv[3:0];
		e[4]    = receive_ready_flag_m[0];
		e[5]    = ovr_m[0];
		e[6]    = lv[4];
		e[7]    = lv[5];
		e[11:8] = stk_m[3:0];
		e[16]   = en[0];
		e[17]   = en[1];
		return e;
	endfunction

	// ---------------------------------------------------------------
	// watchdog: the sequence needs a few thousand cycles at most
	// ---------------------------------------------------------------
	initial
	begin
		#200000;
		errors++;
		summarize();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		i_clk = 1'b0;
		i_rst = 1'b1;
		{psel, penable, pwrite, rx_load, rx_take} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		lv = 6'h00;
		en = 2'h0;
		evt = 4'h0;
		{errors, checks_done, mask_m, stk_m, receive_ready_flag_m, ovr_m} = '0;
		seed = $urandom(80616);
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		apb(1'b0, `SCI_OFS_MASK_STATE, 32'h0000_0000);
		chk("mask after reset", 32'h0000_0000, rd);
		for (int it = 0; it < 40; it++)
		begin
			@(posedge i_clk);
			lv <= 6'($urandom);
			en <= 2'($urandom);
			sv = $urandom;
			apb(1'b1, `SCI_OFS_EN_SET, sv);
			mask_m = mask_m | int'(sv[11:0]);
			if (it % 2 == 1)
			begin
				sv = $urandom;
				apb(1'b1, `SCI_OFS_EN_CLEAR, sv);
				mask_m = mask_m & ~int'(sv[11:0]);
			end
			sv = $urandom;
			pulse_ev(sv[3:0]);
			stk_m = stk_m | int'(sv[3:0]);
			if (sv[4])
			begin
				@(posedge i_clk);
				rx_load <= 1'b1;
				@(posedge i_clk);
				rx_load <= 1'b0;
				ovr_m = ovr_m | receive_ready_flag_m;
				receive_ready_flag_m = 1;
			end
			if (sv[5])
			begin
				@(posedge i_clk);
				rx_take <= 1'b1;
				@(posedge i_clk);
				rx_take <= 1'b0;
				receive_ready_flag_m = 0;
			end
			repeat (2) @(posedge i_clk);
			apb(1'b0, `SCI_OFS_MASK_STATE, 32'h0000_0000);
			chk("mask", 32'(mask_m), rd);
			chk("irq", {31'h0, |(exp_status() & 32'(mask_m))}, {31'h0, irq});
			apb(1'b0, `SCI_OFS_STATUS, 32'h0000_0000);
			chk("status", exp_status(), rd);
			stk_m = 0;
			ovr_m = 0;
			apb(1'b0, `SCI_OFS_STATUS, 32'h0000_0000);
			chk("status reread", exp_status(), rd);
		end
		apb(1'b0, `SCI_OFS_EN_SET, 32'h0000_0000);
		chk("write only read", 32'h0000_0000, rd);
		apb(1'b1, `SCI_OFS_MASK_STATE, 32'hFFFF_FFFF);
		apb(1'b0, `SCI_OFS_MASK_STATE, 32'h0000_0000);
		chk("mask read only", 32'(mask_m), rd);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, er});
		chk("unmapped data", 32'h0000_0000, rd);
		summarize();
	end

endmodule
